// ===== core/ktb_pkg.sv
package ktb_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  REG_BER_IDX       = 8'hd3;
    localparam logic [7:0]  REG_COEF_IDX      = 8'hd4;
    localparam logic [7:0]  REG_OVR_IDX       = 8'he0;

    // interval control fields
    localparam int          FINE_LSB          = 10;
    localparam int          FINE_MSB          = 19;
    localparam int          COARSE_LSB        = 20;
    localparam int          COARSE_MSB        = 29;
    localparam int          CNT_W             = 10;

    // coefficient request fields
    localparam int          PRE_LSB           = 0;
    localparam int          MAIN_LSB          = 2;
    localparam int          POST_LSB          = 4;
    localparam int          COEF_W            = 6;
    localparam int          INIT_BIT          = 6;

    // override control fields
    localparam int          OVR_EN_BIT        = 0;
    localparam int          BUSY_BIT          = 1;

    // reset values
    localparam logic [9:0]  FINE_RST_SIM      = 10'h000;
    localparam logic [9:0]  FINE_RST_HW       = 10'h003;
    localparam logic [9:0]  COARSE_RST        = 10'h000;
    localparam logic [6:0]  COEF_RST          = 7'h00;
    localparam logic        OVR_RST           = 1'b0;

    // training frames per unit of the interval count
    localparam int          FRAMES_PER_UNIT   = 1000;

    typedef enum logic [1:0] {
        KTB_HOLD = 2'b00,
        KTB_INC  = 2'b01,
        KTB_DEC  = 2'b10,
        KTB_RSVD = 2'b11
    } ktb_coef_code_t;
endpackage : ktb_pkg

// ===== core/ktb_ber_timer.sv
`timescale 1ns/1ps
module ktb_ber_timer #(
    parameter int FRAMES_PER_UNIT = ktb_pkg::FRAMES_PER_UNIT
) (
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    input  wire logic                     step_start,
    input  wire logic                     frame_tick,
    input  wire logic [ktb_pkg::CNT_W-1:0] fine_count,
    input  wire logic [ktb_pkg::CNT_W-1:0] coarse_count,
    output logic                          window_busy,
    output logic                          window_done
);
    import ktb_pkg::*;

    typedef enum logic {KTB_IDLE, KTB_RUN} ktb_tmr_state_t;

    ktb_tmr_state_t   state, next_state;
    logic [19:0]      target, next_target;
    logic [19:0]      unit_cnt, next_unit_cnt;
    logic [31:0]      frame_cnt, next_frame_cnt;
    logic             next_window_done;

    // coarse zero: fine units; else coarse times fine units
    function automatic logic [19:0] units_of(input logic [CNT_W-1:0] f,
                                             input logic [CNT_W-1:0] c);
        if (c == '0) begin
            return {10'h000, f};
        end
        return c * f;
    endfunction : units_of

    always_comb begin
        next_state       = state;
        next_target      = target;
        next_unit_cnt    = unit_cnt;
        next_frame_cnt   = frame_cnt;
        next_window_done = 1'b0;
        case (state)
            KTB_IDLE: begin
                if (step_start) begin
                    next_state     = KTB_RUN;
                    next_target    = units_of(fine_count, coarse_count);
                    next_unit_cnt  = 20'h00000;
                    next_frame_cnt = 32'h0;
                end
            end
            KTB_RUN: begin
                if (frame_tick) begin
                    // zero window closes at the first frame
                    if (target == 20'h00000) begin
                        next_state       = KTB_IDLE;
                        next_window_done = 1'b1;
                    end else if (frame_cnt == 32'(FRAMES_PER_UNIT - 1)) begin
                        next_frame_cnt = 32'h0;
                        next_unit_cnt  = unit_cnt + 20'h00001;
                        if (unit_cnt + 20'h00001 == target) begin
                            next_state       = KTB_IDLE;
                            next_window_done = 1'b1;
                        end
                    end else begin
                        next_frame_cnt = frame_cnt + 32'h1;
                    end
                end
            end
            default: next_state = KTB_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= KTB_IDLE;
            target      <= 20'h00000;
            unit_cnt    <= 20'h00000;
            frame_cnt   <= 32'h0;
            window_done <= 1'b0;
            window_busy <= 1'b0;
        end else begin
            state       <= next_state;
            target      <= next_target;
            unit_cnt    <= next_unit_cnt;
            frame_cnt   <= next_frame_cnt;
            window_done <= next_window_done;
            window_busy <= (next_state == KTB_RUN);
        end
    end
endmodule : ktb_ber_timer

// ===== core/ktb_top.sv
// What this block does
// - 10-bit read-write fine frame count at bits 19:10, used when coarse is zero.
// - with coarse zero, fine count scales the bit-error window: 3, 25, 250 steps.
// - fine count resets to zero in simulation builds.
// - coefficient bits 5:0 mirror first word of our transmitted training frame.
// - coefficient bits read-only normally, writable only while override enable is set.
// - post-cursor request in bits 5:4: 01 increment, 00 hold.
// - bit 6 set asks the partner to initialize its transmit equalizer.
// - code 10 decrement, 11 reserved; main 3:2 and pre 1:0 share the encoding.
// - 10-bit coarse count at bits 29:20 multiplies the fine count per step.
`timescale 1ns/1ps
module ktb_top #(
    parameter bit SIM_BUILD       = 1'b0,
    parameter int FRAMES_PER_UNIT = ktb_pkg::FRAMES_PER_UNIT
) (
    input  wire logic                      core_clk,
    input  wire logic                      arst_n,
    input  wire logic [7:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [ktb_pkg::COEF_W-1:0] train_coef_req,
    input  wire logic                      train_init_req,
    input  wire logic                      eq_step_start,
    input  wire logic                      train_frame_tick,
    output logic [ktb_pkg::COEF_W-1:0]     local_coefficient_request,
    output logic                           partner_equalizer_init_request,
    output logic                           coef_override_active,
    output logic                           ber_window_busy,
    output logic                           ber_window_done
);
    import ktb_pkg::*;

    localparam logic [9:0] FINE_RST = SIM_BUILD ? FINE_RST_SIM : FINE_RST_HW;

    // bus handshake and readback
    logic                  next_waitrequest;
    logic [31:0]           next_readdata;
    logic                  wr_take;
    logic                  rd_take;

    // interval control
    logic [CNT_W-1:0]      fine_count, next_fine_count;
    logic [CNT_W-1:0]      coarse_count, next_coarse_count;

    // coefficient requests and override
    logic [COEF_W-1:0]     next_coef;
    logic                  next_init;
    logic                  next_override;

    // reserved code falls back to hold
    function automatic logic [1:0] sane_code(input logic [1:0] c);
        return (c == KTB_RSVD) ? KTB_HOLD : c;
    endfunction : sane_code

    // byte-enable merge of a 32-bit word
    function automatic logic [31:0] merge(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [31:0] ber_word(input logic [CNT_W-1:0] f,
                                             input logic [CNT_W-1:0] c);
        logic [31:0] w;
        w = 32'h0;
        w[FINE_MSB:FINE_LSB]     = f;
        w[COARSE_MSB:COARSE_LSB] = c;
        return w;
    endfunction : ber_word

    function automatic logic [31:0] coef_word(input logic [COEF_W-1:0] q,
                                              input logic              ini);
        logic [31:0] w;
        w = 32'h0;
        w[COEF_W-1:0] = q;
        w[INIT_BIT]   = ini;
        return w;
    endfunction : coef_word

    // one wait cycle per access; request completes when waitrequest is low
    assign wr_take = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && !avs_waitrequest;

    always_comb begin
        next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
        next_readdata    = 32'h0;
        if (avs_read && avs_waitrequest) begin
            case (avs_address)
                REG_BER_IDX:  next_readdata = ber_word(fine_count, coarse_count);
                REG_COEF_IDX: next_readdata = coef_word(local_coefficient_request,
                                                        partner_equalizer_init_request);
                REG_OVR_IDX: begin
                    next_readdata[OVR_EN_BIT] = coef_override_active;
                    next_readdata[BUSY_BIT]   = ber_window_busy;
                end
                default:      next_readdata = 32'h0;
            endcase
        end else if (rd_take) begin
            next_readdata = avs_readdata;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // interval control register
    always_comb begin
        logic [31:0] w;
        w                 = 32'h0;
        next_fine_count   = fine_count;
        next_coarse_count = coarse_count;
        if (wr_take && avs_address == REG_BER_IDX) begin
            w                 = merge(ber_word(fine_count, coarse_count),
                                      avs_writedata, avs_byteenable);
            next_fine_count   = w[FINE_MSB:FINE_LSB];
            next_coarse_count = w[COARSE_MSB:COARSE_LSB];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fine_count   <= FINE_RST;
            coarse_count <= COARSE_RST;
        end else begin
            fine_count   <= next_fine_count;
            coarse_count <= next_coarse_count;
        end
    end

    // override enable and coefficient request word
    always_comb begin
        logic [31:0] w;
        w             = 32'h0;
        next_override = coef_override_active;
        next_coef     = local_coefficient_request;
        next_init     = partner_equalizer_init_request;
        if (wr_take && avs_address == REG_OVR_IDX && avs_byteenable[0]) begin
            next_override = avs_writedata[OVR_EN_BIT];
        end
        if (!coef_override_active) begin
            // training logic owns the word; bus writes dropped
            next_coef = {sane_code(train_coef_req[POST_LSB +: 2]),
                         sane_code(train_coef_req[MAIN_LSB +: 2]),
                         sane_code(train_coef_req[PRE_LSB +: 2])};
            next_init = train_init_req;
        end else if (wr_take && avs_address == REG_COEF_IDX) begin
            w         = merge(coef_word(local_coefficient_request,
                                        partner_equalizer_init_request),
                              avs_writedata, avs_byteenable);
            next_coef = {sane_code(w[POST_LSB +: 2]),
                         sane_code(w[MAIN_LSB +: 2]),
                         sane_code(w[PRE_LSB +: 2])};
            next_init = w[INIT_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            coef_override_active           <= OVR_RST;
            local_coefficient_request      <= COEF_RST[COEF_W-1:0];
            partner_equalizer_init_request <= COEF_RST[INIT_BIT];
        end else begin
            coef_override_active           <= next_override;
            local_coefficient_request      <= next_coef;
            partner_equalizer_init_request <= next_init;
        end
    end

    // bit-error measurement window per equalization step
    ktb_ber_timer #(
        .FRAMES_PER_UNIT (FRAMES_PER_UNIT)
    ) u_ber_timer (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .step_start   (eq_step_start),
        .frame_tick   (train_frame_tick),
        .fine_count   (fine_count),
        .coarse_count (coarse_count),
        .window_busy  (ber_window_busy),
        .window_done  (ber_window_done)
    );
endmodule : ktb_top

// ===== sim/ktb_checker.sv
`timescale 1ns/1ps
module ktb_checker
    import ktb_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic                       avs_waitrequest,
    input  wire logic [ktb_pkg::COEF_W-1:0] train_coef_req,
    input  wire logic                       train_init_req,
    input  wire logic                       eq_step_start,
    input  wire logic                       train_frame_tick,
    input  wire logic [ktb_pkg::COEF_W-1:0] local_coefficient_request,
    input  wire logic                       partner_equalizer_init_request,
    input  wire logic                       coef_override_active,
    input  wire logic                       ber_window_busy,
    input  wire logic                       ber_window_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // reserved code comes out as hold
    function automatic logic [5:0] clean(input logic [5:0] w);
        for (int i = 0; i < 6; i += 2) begin
            if (w[i+:2] == 2'b11) w[i+:2] = 2'b00;
        end
        return w;
    endfunction : clean

    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_wait_answer: assert property (s_req |=> s_ack)
        else $error("bus access not answered in one wait state");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest dropped without request");
    a_coef_follow: assert property (
        !coef_override_active && $past(!coef_override_active) && $past(arst_n)
        |-> local_coefficient_request == clean($past(train_coef_req)))
        else $error("coefficient word not following training");
    a_init_follow: assert property (
        !coef_override_active && $past(!coef_override_active) && $past(arst_n)
        |-> partner_equalizer_init_request == $past(train_init_req))
        else $error("initialize bit not following training");
    a_no_reserved: assert property (local_coefficient_request[5:4] != 2'b11
        && local_coefficient_request[3:2] != 2'b11 && local_coefficient_request[1:0] != 2'b11)
        else $error("reserved coefficient code sent");
    a_busy_start: assert property (
        eq_step_start && !ber_window_busy |=> ber_window_busy)
        else $error("window did not start");
    a_busy_hold: assert property (
        ber_window_busy |=> ber_window_busy || ber_window_done)
        else $error("window ended without done");
    a_done_end: assert property (ber_window_done |->
        (!ber_window_busy && $past(ber_window_busy)) ##1 !ber_window_done)
        else $error("done pulse malformed");
    a_done_tick: assert property (ber_window_done |-> $past(train_frame_tick))
        else $error("done without a completing frame");
endmodule : ktb_checker

bind ktb_top ktb_checker ktb_checker_i (
    .core_clk(core_clk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .train_coef_req(train_coef_req),
    .train_init_req(train_init_req), .eq_step_start(eq_step_start),
    .train_frame_tick(train_frame_tick), .local_coefficient_request(local_coefficient_request),
    .partner_equalizer_init_request(partner_equalizer_init_request),
    .coef_override_active(coef_override_active), .ber_window_busy(ber_window_busy),
    .ber_window_done(ber_window_done)
);

// ===== sim/ktb_partner.sv
`timescale 1ns/1ps
module ktb_partner (
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    input  wire logic                       run,
    input  wire logic [3:0]                 gap,
    input  wire logic [ktb_pkg::COEF_W-1:0] coef_word,
    input  wire logic                       init_word,
    output logic                            frame_tick,
    output logic [6:0]                      seen_word
);
    logic [3:0] cnt;

    // frames arrive every gap+1 cycles, slow or prompt
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt        <= 4'h0;
            frame_tick <= 1'b0;
            seen_word  <= 7'h00;
        end else begin
            frame_tick <= 1'b0;
            if (run && cnt >= gap) begin
                cnt        <= 4'h0;
                frame_tick <= 1'b1;
            end else if (run) begin
                cnt <= cnt + 4'h1;
            end
            if (frame_tick) seen_word <= {init_word, coef_word};
        end
    end
endmodule : ktb_partner

// ===== sim/ktb_top_test.sv
`timescale 1ns/1ps
module ktb_top_test;
    import ktb_pkg::*;
    localparam int FPU = 2;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [5:0]  train_coef_req = 6'h00;
    logic        train_init_req = 1'b0;
    logic        eq_step_start = 1'b0;
    logic        train_frame_tick;
    logic [5:0]  local_coefficient_request;
    logic        partner_equalizer_init_request;
    logic        run = 1'b0;
    logic [3:0]  gap = 4'h1;
    logic [6:0]  seen_word;
    logic        ovr_flag;
    logic        win_busy;
    logic        win_done;
    int          fail_count = 0;
    int          num_checks = 0;
    int          ticks = 0;
    logic [31:0] exp_q[$];

    ktb_top #(.SIM_BUILD(1'b1), .FRAMES_PER_UNIT(FPU)) ktb_top_i (
        .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .train_coef_req(train_coef_req), .train_init_req(train_init_req),
        .eq_step_start(eq_step_start), .train_frame_tick(train_frame_tick),
        .local_coefficient_request(local_coefficient_request),
        .partner_equalizer_init_request(partner_equalizer_init_request),
        .coef_override_active(ovr_flag), .ber_window_busy(win_busy),
        .ber_window_done(win_done));
    ktb_partner ktb_partner_i (.core_clk(core_clk), .arst_n(arst_n), .run(run), .gap(gap),
        .coef_word(local_coefficient_request), .init_word(partner_equalizer_init_request),
        .frame_tick(train_frame_tick), .seen_word(seen_word));

    always #25 core_clk = ~core_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic ber(input logic [9:0] f, input logic [9:0] c, input int exp_ticks);
        int n = 0;
        run <= 1'b0;
        bus(1'b1, REG_BER_IDX, {2'b00, c, f, 10'h000});
        gap <= 4'($urandom_range(3));
        ticks = 0;
        // second start cycle lands while busy and must be ignored
        eq_step_start <= 1'b1;
        repeat (2) @(posedge core_clk);
        eq_step_start <= 1'b0;
        run <= 1'b1;
        while (win_done !== 1'b1 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 5000) fail_count++;
        run <= 1'b0;
        check("window ticks", 32'(exp_ticks), 32'(ticks));
    endtask : ber

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    function automatic logic [1:0] fld(input int v);
        return (v == 3) ? 2'b00 : 2'(v);
    endfunction : fld

    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) check("readdata", exp_q.pop_front(), avs_readdata);
        if (win_busy === 1'b1 && train_frame_tick === 1'b1) ticks++;
    end

    initial begin
        #2_000_000;
        fail_count++;
        wrap_up();
    end

    initial begin
        logic [31:0] d;
        logic [5:0]  e;
        void'($urandom(57));
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(REG_BER_IDX, 32'h0);
        rd(REG_OVR_IDX, 32'h0);
        bus(1'b1, 8'h10, 32'hffffffff);
        rd(8'h10, 32'h0);
        $display("test reset and unmapped done");
        repeat (4) begin
            d = $urandom();
            bus(1'b1, REG_BER_IDX, d);
            rd(REG_BER_IDX, d & 32'h3ffffc00);
        end
        $display("test interval fields done");
        run <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            train_coef_req <= {2'(c), 2'(3 - c), 2'(c)};
            train_init_req <= c[0];
            e = {fld(c), fld(3 - c), fld(c)};
            bus(1'b1, REG_COEF_IDX, 32'h7f);
            rd(REG_COEF_IDX, {25'h0, c[0], e});
            repeat (2) @(posedge core_clk);
            check("coef word", {26'h0, e}, {26'h0, local_coefficient_request});
            check("partner word", {25'h0, c[0], e}, {25'h0, seen_word});
        end
        $display("test training codes done");
        bus(1'b1, REG_OVR_IDX, 32'h1);
        train_coef_req <= 6'h15;
        train_init_req <= 1'b0;
        rd(REG_COEF_IDX, 32'h40);
        check("override flag", 32'h1, {31'h0, ovr_flag});
        bus(1'b1, REG_COEF_IDX, 32'h29);
        rd(REG_COEF_IDX, 32'h29);
        check("override word", 32'h29,
              {partner_equalizer_init_request, local_coefficient_request});
        bus(1'b1, REG_OVR_IDX, 32'h0);
        repeat (2) @(posedge core_clk);
        check("override clear", 32'h0, {31'h0, ovr_flag});
        check("follow word", 32'h15,
              {partner_equalizer_init_request, local_coefficient_request});
        $display("test override done");
        ber(10'd3, 10'd0, 3 * FPU);
        ber(10'd3, 10'd2, 6 * FPU);
        ber(10'd0, 10'd0, 1);
        $display("test bit error window done");
        wrap_up();
    end
endmodule : ktb_top_test
